/* File: hdl/temp_conv_map.svh */
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef TEMP_CONV_MAP_SVH
`define TEMP_CONV_MAP_SVH

`define CFG_OFFSET        8'h00
`define TEMP_OFFSET       8'h04
`define STATUS_OFFSET     8'h08

`define CFG_SHUTDOWN_BIT  0
`define CFG_ONE_SHOT_BIT  1
`define CFG_RES_LSB       2
`define CFG_RES_MSB       3
`define CFG_RESET         4'h0
`define TEMP_RESET        12'h000
`define TEMP_WIDTH        12

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`define CLK_MHZ           100
`define ACTIVE_TIME_US    26000
`define PERIOD0_TIME_US   27500
`define PERIOD1_TIME_US   55000
`define PERIOD2_TIME_US   110000
`define PERIOD3_TIME_US   220000
`define ACTIVE_CYCLES     (`ACTIVE_TIME_US * `CLK_MHZ)
`define PERIOD0_CYCLES    (`PERIOD0_TIME_US * `CLK_MHZ)
`define PERIOD1_CYCLES    (`PERIOD1_TIME_US * `CLK_MHZ)
`define PERIOD2_CYCLES    (`PERIOD2_TIME_US * `CLK_MHZ)
`define PERIOD3_CYCLES    (`PERIOD3_TIME_US * `CLK_MHZ)

`endif

/* File: hdl/temp_conv_pkg.sv */
// types shared by the conversion sequencer
package temp_conv_pkg;

    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_IDLE   = 4'h2,
        ST_SHUT   = 4'h4,
        ST_SINGLE = 4'h8
    } conv_state_t;

    typedef struct packed {
        logic resolution_select_upper;
        logic resolution_select_lower;
        logic one_shot_trigger;
        logic shutdown_control;
    } cfg_t;

endpackage

/* File: hdl/conv_timer.sv */
// free cycle counter that measures time inside a conversion period
`timescale 1ns/1ps
module conv_timer #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             restart,
    input  wire logic             hold,
    output logic [WIDTH-1:0]      count
);
    logic [WIDTH-1:0] next_count;

    always_comb begin
        if (restart || hold) begin
            next_count = '0;
        end else begin
            next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule // conv_timer

/* File: hdl/temp_conversion_control.sv */
// conversion sequencer with result register and axi4-lite slave
// Functional notes
// - after reset run continuous conversions, each result overwrites the last
// - resolution code 00..11 selects 9, 10, 11 or 12 result bits
// - continuous period follows resolution code: 27.5, 55, 110, 220 ms
// - converter active 26 ms each period, low-power idle for the rest
// - result is 12-bit two's complement, lsb 0.0625 degrees
// - result register is zero after reset until first conversion ends
// - unused result bits and bits below the resolution read zero
// - shutdown set: finish running conversion, then power down
// - shutdown clear: keep converting continuously without interruption
// - writing one-shot 1 while shut down starts exactly one conversion
// - after the single conversion is stored, return to shutdown
// - one-shot bit always reads back zero
// - single conversion takes 26 ms, no idle padding
`timescale 1ns/1ps
`include "temp_conv_map.svh"
module temp_conversion_control #(
    parameter int ADDR_WIDTH     = 8,
    parameter int ACTIVE_CYCLES  = `ACTIVE_CYCLES,
    parameter int PERIOD0_CYCLES = `PERIOD0_CYCLES,
    parameter int PERIOD1_CYCLES = `PERIOD1_CYCLES,
    parameter int PERIOD2_CYCLES = `PERIOD2_CYCLES,
    parameter int PERIOD3_CYCLES = `PERIOD3_CYCLES
) (
    input  wire logic                  REF_CLK,
    input  wire logic                  SYS_RST,
    input  wire logic [ADDR_WIDTH-1:0] S_AXI_AWADDR,
    input  wire logic                  S_AXI_AWVALID,
    output logic                       S_AXI_AWREADY,
    input  wire logic [31:0]           S_AXI_WDATA,
    input  wire logic [3:0]            S_AXI_WSTRB,
    input  wire logic                  S_AXI_WVALID,
    output logic                       S_AXI_WREADY,
    output logic [1:0]                 S_AXI_BRESP,
    output logic                       S_AXI_BVALID,
    input  wire logic                  S_AXI_BREADY,
    input  wire logic [ADDR_WIDTH-1:0] S_AXI_ARADDR,
    input  wire logic                  S_AXI_ARVALID,
    output logic                       S_AXI_ARREADY,
    output logic [31:0]                S_AXI_RDATA,
    output logic [1:0]                 S_AXI_RRESP,
    output logic                       S_AXI_RVALID,
    input  wire logic                  S_AXI_RREADY,
    input  wire logic [11:0]           SAMPLE_DATA,
    output logic                       CONVERTER_ENABLE,
    output logic                       LOW_POWER_IDLE,
    output logic                       POWERED_DOWN,
    output logic [11:0]                TEMP_RESULT
);

    // register index decode shared by read and write paths
    function automatic logic [1:0] reg_index(
        input logic [ADDR_WIDTH-1:0] addr
    );
        logic [7:0] low;
        low = addr[7:0];
        if (low == `CFG_OFFSET) begin
            reg_index = 2'h0;
        end else if (low == `TEMP_OFFSET) begin
            reg_index = 2'h1;
        end else if (low == `STATUS_OFFSET) begin
            reg_index = 2'h2;
        end else begin
            reg_index = 2'h3;
        end
    endfunction

    function automatic logic [11:0] res_mask(input logic [1:0] code);
        case (code)
            2'h0:    res_mask = 12'hff8;
            2'h1:    res_mask = 12'hffc;
            2'h2:    res_mask = 12'hffe;
            default: res_mask = 12'hfff;
        endcase
    endfunction

    function automatic logic [31:0] period_for(input logic [1:0] code);
        case (code)
            2'h0:    period_for = 32'(PERIOD0_CYCLES);
            2'h1:    period_for = 32'(PERIOD1_CYCLES);
            2'h2:    period_for = 32'(PERIOD2_CYCLES);
            default: period_for = 32'(PERIOD3_CYCLES);
        endcase
    endfunction
    // sample synchroniser: the analog side is not on REF_CLK
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] sync3;
    logic [11:0] sample;
    logic [11:0] next_sample;

    always_comb begin
        next_sample = sample;
        if (sync2 == sync3) begin
            next_sample = sync3;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            sync1  <= 12'h000;
            sync2  <= 12'h000;
            sync3  <= 12'h000;
            sample <= 12'h000;
        end else begin
            sync1  <= SAMPLE_DATA;
            sync2  <= sync1;
            sync3  <= sync2;
            sample <= next_sample;
        end
    end

    // configuration and write channel
    temp_conv_pkg::cfg_t cfg;
    temp_conv_pkg::cfg_t next_cfg;
    logic                  aw_full;
    logic                  next_aw_full;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic [ADDR_WIDTH-1:0] next_aw_addr;
    logic                  w_full;
    logic                  next_w_full;
    logic [31:0]           w_data;
    logic [31:0]           next_w_data;
    logic [3:0]            w_strb;
    logic [3:0]            next_w_strb;
    logic                  bvalid;
    logic                  next_bvalid;
    logic [1:0]            bresp;
    logic [1:0]            next_bresp;
    logic                  one_shot_write;
    logic                  do_write;

    assign S_AXI_AWREADY = !aw_full && !bvalid;
    assign S_AXI_WREADY  = !w_full && !bvalid;
    assign S_AXI_BVALID  = bvalid;
    assign S_AXI_BRESP   = bresp;
    assign do_write      = aw_full && w_full && !bvalid;

    always_comb begin
        next_cfg       = cfg;
        next_aw_full   = aw_full;
        next_aw_addr   = aw_addr;
        next_w_full    = w_full;
        next_w_data    = w_data;
        next_w_strb    = w_strb;
        next_bvalid    = bvalid;
        next_bresp     = bresp;
        one_shot_write = 1'b0;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_full = 1'b1;
            next_aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_full = 1'b1;
            next_w_data = S_AXI_WDATA;
            next_w_strb = S_AXI_WSTRB;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `RESP_OKAY;
            if (reg_index(aw_addr) == 2'h3) begin
                next_bresp = `RESP_SLVERR;
            end else if (reg_index(aw_addr) == 2'h0 && w_strb[0]) begin
                next_cfg.shutdown_control = w_data[`CFG_SHUTDOWN_BIT];
                next_cfg.resolution_select_upper = w_data[`CFG_RES_MSB];
                next_cfg.resolution_select_lower = w_data[`CFG_RES_LSB];
                one_shot_write = w_data[`CFG_ONE_SHOT_BIT];
            end
        end
        if (bvalid && S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
        // the trigger is an action, never stored
        next_cfg.one_shot_trigger = 1'b0;
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            cfg     <= temp_conv_pkg::cfg_t'(`CFG_RESET);
            aw_full <= 1'b0;
            aw_addr <= '0;
            w_full  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
        end else begin
            cfg     <= next_cfg;
            aw_full <= next_aw_full;
            aw_addr <= next_aw_addr;
            w_full  <= next_w_full;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
        end
    end

    // conversion sequencer
    temp_conv_pkg::conv_state_t state;
    temp_conv_pkg::conv_state_t next_state;
    logic [1:0]  res_code;
    logic [31:0] elapsed;
    logic        conv_done;
    logic        period_end;
    logic        timer_restart;
    logic [11:0] next_result;

    assign res_code = {cfg.resolution_select_upper,
                       cfg.resolution_select_lower};
    // same active time whatever the resolution
    assign conv_done = (state == temp_conv_pkg::ST_ACTIVE ||
                        state == temp_conv_pkg::ST_SINGLE) &&
                       elapsed == 32'(ACTIVE_CYCLES - 1);
    // >= so a shorter period picked mid-idle cannot hang the loop
    assign period_end = state == temp_conv_pkg::ST_IDLE &&
                        elapsed >= period_for(res_code) - 32'h1;

    conv_timer #(.WIDTH(32)) u_timer (
        .clk     (REF_CLK),
        .rst     (SYS_RST),
        .restart (timer_restart),
        .hold    (state == temp_conv_pkg::ST_SHUT),
        .count   (elapsed)
    );

    always_comb begin
        next_state  = state;
        next_result = TEMP_RESULT;
        if (conv_done) begin
            // whole word at once, never byte by byte
            next_result = sample & res_mask(res_code);
        end
        case (state)
            temp_conv_pkg::ST_ACTIVE: begin
                if (conv_done) begin
                    if (cfg.shutdown_control) begin
                        next_state = temp_conv_pkg::ST_SHUT;
                    end else begin
                        next_state = temp_conv_pkg::ST_IDLE;
                    end
                end
            end
            temp_conv_pkg::ST_IDLE: begin
                if (cfg.shutdown_control) begin
                    next_state = temp_conv_pkg::ST_SHUT;
                end else if (period_end) begin
                    next_state = temp_conv_pkg::ST_ACTIVE;
                end
            end
            temp_conv_pkg::ST_SHUT: begin
                if (!cfg.shutdown_control) begin
                    next_state = temp_conv_pkg::ST_ACTIVE;
                end else if (one_shot_write) begin
                    next_state = temp_conv_pkg::ST_SINGLE;
                end
            end
            temp_conv_pkg::ST_SINGLE: begin
                if (conv_done) begin
                    next_state = temp_conv_pkg::ST_SHUT;
                end
            end
            default: begin
                next_state = temp_conv_pkg::ST_ACTIVE;
            end
        endcase
        timer_restart = next_state != state &&
                        (next_state == temp_conv_pkg::ST_ACTIVE ||
                         next_state == temp_conv_pkg::ST_SINGLE);
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state            <= temp_conv_pkg::ST_ACTIVE;
            TEMP_RESULT      <= `TEMP_RESET;
            CONVERTER_ENABLE <= 1'b1;
            LOW_POWER_IDLE   <= 1'b0;
            POWERED_DOWN     <= 1'b0;
        end else begin
            state            <= next_state;
            TEMP_RESULT      <= next_result;
            CONVERTER_ENABLE <= next_state == temp_conv_pkg::ST_ACTIVE ||
                                next_state == temp_conv_pkg::ST_SINGLE;
            LOW_POWER_IDLE   <= next_state == temp_conv_pkg::ST_IDLE;
            POWERED_DOWN     <= next_state == temp_conv_pkg::ST_SHUT;
        end
    end

    // read channel
    logic        rvalid;
    logic        next_rvalid;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0]  rresp;
    logic [1:0]  next_rresp;

    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_RVALID  = rvalid;
    assign S_AXI_RDATA   = rdata;
    assign S_AXI_RRESP   = rresp;
    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (S_AXI_ARVALID && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            case (reg_index(S_AXI_ARADDR))
                2'h0: next_rdata = {28'h0, cfg};
                2'h1: next_rdata = {20'h0, TEMP_RESULT};
                2'h2: next_rdata = {27'h0, CONVERTER_ENABLE, state};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `RESP_SLVERR;
                end
            endcase
        end else if (rvalid && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end
endmodule // temp_conversion_control

/* File: test/temp_conversion_control_properties.sv */
// port-level checks on the conversion sequencer
`timescale 1ns/1ps
module temp_conv_checker #(
    parameter int ACTIVE_CYCLES = 20
) (
    input wire logic        REF_CLK,
    input wire logic        SYS_RST,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_BVALID,
    input wire logic        CONVERTER_ENABLE,
    input wire logic        LOW_POWER_IDLE,
    input wire logic        POWERED_DOWN,
    input wire logic [11:0] TEMP_RESULT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    int run_len;
    // counts cycles of one converter run, cleared between runs
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || !CONVERTER_ENABLE) begin
            run_len <= 0;
        end else begin
            run_len <= run_len + 1;
        end
    end
    AST_ONE_MODE: assert property (
        $onehot({CONVERTER_ENABLE, LOW_POWER_IDLE, POWERED_DOWN}))
        else $error("power mode outputs not one-hot");
    AST_ACTIVE_LEN: assert property (
        $fell(CONVERTER_ENABLE) |-> run_len == ACTIVE_CYCLES)
        else $error("converter run length wrong");
    AST_RESULT_STEP: assert property (
        $changed(TEMP_RESULT) |-> $fell(CONVERTER_ENABLE))
        else $error("result changed outside conversion end");
    AST_RESET_ZERO: assert property (
        $fell(SYS_RST) |-> TEMP_RESULT == 12'h000)
        else $error("result not zero after reset");
    AST_IDLE_BOUND: assert property (
        $rose(LOW_POWER_IDLE) |-> ##[1:80] !LOW_POWER_IDLE)
        else $error("idle did not end");
    // a cleared shutdown bit wakes one edge after the write response
    AST_SHUT_WAKE: assert property (
        $fell(POWERED_DOWN) |-> $rose(S_AXI_BVALID)
            || $past(S_AXI_BVALID))
        else $error("left shutdown without a write");
    AST_ENABLE_RISE: assert property (
        $rose(CONVERTER_ENABLE) |-> $past(LOW_POWER_IDLE)
            || $rose(S_AXI_BVALID) || $past(S_AXI_BVALID))
        else $error("conversion started without cause");
    AST_READ_ANSWER: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID
            && S_AXI_RDATA[31:12] == 20'h00000)
        else $error("read answer late or upper bits set");
endmodule // temp_conv_checker
bind temp_conversion_control temp_conv_checker #(
    .ACTIVE_CYCLES(ACTIVE_CYCLES)
) temp_conv_checker_i (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BVALID(S_AXI_BVALID),
    .CONVERTER_ENABLE(CONVERTER_ENABLE), .LOW_POWER_IDLE(LOW_POWER_IDLE),
    .POWERED_DOWN(POWERED_DOWN), .TEMP_RESULT(TEMP_RESULT)
);

/* File: test/conv_source_model.sv */
// behavioural front end of the converter feeding raw codes
`timescale 1ns/1ps
module conv_source_model (
    input wire logic        clk,
    input wire logic        enable,
    input wire logic [11:0] level,
    output logic [11:0]     sample
);
    // unpowered front end shows the inverse, so a capture outside
    // a conversion cannot match by luck
    always_ff @(posedge clk) begin
        sample <= enable ? level : ~level;
    end
endmodule // conv_source_model

/* File: test/temp_conversion_control_tb_top.sv */
// scenario testbench of the conversion sequencer
`timescale 1ns/1ps
`include "temp_conv_map.svh"
module temp_conversion_control_tb_top;
    localparam int ACT = 20;
    localparam int PER [4] = '{30, 40, 60, 80};
    localparam logic [11:0] VAL [4] = '{12'hc9b, 12'h7ff, 12'h190, 12'he75};
    localparam logic [11:0] MSK [4] = '{12'hff8, 12'hffc, 12'hffe, 12'hfff};
    logic ref_clk = 0, sys_rst = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [11:0] level = 12'h000, sample, temp_result;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic conv_en, idle, shut;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_data;
    int errors = 0, tests_run = 0, n;
    temp_conversion_control #(.ACTIVE_CYCLES(ACT), .PERIOD0_CYCLES(30),
        .PERIOD1_CYCLES(40), .PERIOD2_CYCLES(60), .PERIOD3_CYCLES(80)
    ) temp_conversion_control_i (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(aw_ready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
        .S_AXI_BVALID(b_valid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
        .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
        .S_AXI_RREADY(rready), .SAMPLE_DATA(sample),
        .CONVERTER_ENABLE(conv_en), .LOW_POWER_IDLE(idle),
        .POWERED_DOWN(shut), .TEMP_RESULT(temp_result));
    conv_source_model conv_source_model_i (.clk(ref_clk), .enable(conv_en),
        .level(level), .sample(sample));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask
    task automatic do_reset();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
    endtask
    // master holds each channel until its own handshake edge
    task automatic xfer(input logic we, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
        logic ta, tw, tr, td;
        @(posedge ref_clk);
        if (we) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (int i = 0; i < 50; i++) begin
            @(negedge ref_clk);
            ta = awvalid && aw_ready;
            tw = wvalid && w_ready;
            tr = arvalid && ar_ready;
            td = (bready && b_valid) || (rready && r_valid);
            q = r_data;
            r = we ? b_resp : r_resp;
            @(posedge ref_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
            if (td) begin
                bready <= 1'b0;
                rready <= 1'b0;
                return;
            end
        end
        errors++;
        results();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        xfer(1'b1, a, d, q, r);
        check("bresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        xfer(1'b0, a, 32'h0, q, r);
        check("rdata", ed, q);
        check("rresp", {30'h0, er}, {30'h0, r});
    endtask
    // sel 0 waits for a run start, sel 1 for entry to shutdown
    task automatic wait_rise(input int sel, output int cnt);
        logic prev, now;
        prev = 1'b1;
        for (cnt = 1; cnt < 2000; cnt++) begin
            @(negedge ref_clk);
            now = (sel == 0) ? conv_en : shut;
            if (now === 1'b1 && prev === 1'b0) return;
            prev = now;
        end
        errors++;
        results();
    endtask
    task automatic s_reset();
        check("temp_result", 32'h0, {20'h0, temp_result});
        rd(`TEMP_OFFSET, 32'h0, `RESP_OKAY);
        rd(`STATUS_OFFSET, 32'h11, `RESP_OKAY);
        rd(`CFG_OFFSET, 32'h0, `RESP_OKAY);
    endtask
    task automatic s_resolution();
        for (int c = 0; c < 4; c++) begin
            level <= VAL[c];
            wr(`CFG_OFFSET, c << 2, `RESP_OKAY);
            // the first rise only aligns, the second closes a whole period
            wait_rise(0, n);
            wait_rise(0, n);
            check("period", PER[c], n);
            rd(`TEMP_OFFSET, {20'h0, VAL[c] & MSK[c]}, `RESP_OKAY);
        end
    endtask
    task automatic s_shutdown();
        level <= 12'h4b3;
        wait_rise(0, n);
        wr(`CFG_OFFSET, 32'hd, `RESP_OKAY);
        check("still_running", 32'h1, {31'h0, conv_en});
        wait_rise(1, n);
        check("last_result", 32'h4b3, {20'h0, temp_result});
        repeat (200) @(negedge ref_clk);
        check("stays_down", 32'h2, {29'h0, idle, shut, conv_en});
    endtask
    task automatic s_one_shot();
        level <= 12'h004;
        wr(`CFG_OFFSET, 32'hf, `RESP_OKAY);
        wait_rise(1, n);
        // counting starts one edge after the write that starts the run
        check("single_len", ACT, n);
        check("single_result", 32'h004, {20'h0, temp_result});
        rd(`CFG_OFFSET, 32'hd, `RESP_OKAY);
        repeat (200) @(negedge ref_clk);
        check("only_one", 32'h2, {29'h0, idle, shut, conv_en});
    endtask
    task automatic s_bus_resume();
        wr(8'h0c, 32'h1, `RESP_SLVERR);
        rd(8'h0c, 32'h0, `RESP_SLVERR);
        wr(`TEMP_OFFSET, 32'hfff, `RESP_OKAY);
        rd(`TEMP_OFFSET, 32'h004, `RESP_OKAY);
        wr(`CFG_OFFSET, 32'h0, `RESP_OKAY);
        @(negedge ref_clk);
        check("resumed", 32'h1, {31'h0, conv_en});
        wait_rise(0, n);
        wait_rise(0, n);
        check("period_again", PER[0], n);
        do_reset();
        @(negedge ref_clk);
        check("reset_again", 32'h0, {20'h0, temp_result});
    endtask
    initial begin
        do_reset();
        s_reset();
        s_resolution();
        s_shutdown();
        s_one_shot();
        s_bus_resume();
        results();
    end
endmodule // temp_conversion_control_tb_top
